/* File: hdl/stack_misc_regs.sv */
// Stack size and miscellaneous option word registers.
// Assumes a bus front end presents decoded word commands on sys_clk_i.
`timescale 1ns/10ps
module stack_misc_regs (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire stack_misc_pkg::cmd_req_t cmd_i,
  input wire logic conversion_en_i,
  input wire logic load_i,
  input wire logic stack_override_i,
  input wire logic [3:0] nvm_follower_i,
  input wire logic [3:0] strap_follower_i,
  input wire logic [15:0] nvm_option_i,
  input wire logic control_shutdown_i,
  input wire logic fault_restart_i,
  input wire logic retry_mode_i,
  input wire logic [15:0] boot_voltage_level_i,
  input wire logic [15:0] target_write_i,
  input wire logic target_write_en_i,
  output logic [15:0] rdata_o,
  output logic rvalid_o,
  output logic invalid_data_o,
  output logic [3:0] follower_count_o,
  output logic backchannel_en_o,
  output stack_misc_pkg::option_ctl_t option_o,
  output logic [15:0] output_voltage_target_o
);
  import stack_misc_pkg::*;

  logic [3:0] follower_r;
  logic [15:0] option_r;
  logic bch_en_r;
  logic [15:0] target_r;
  logic [15:0] rdata_r;
  logic rvalid_r;
  logic invalid_r;
  logic count_ok;
  logic stack_wr;
  logic [3:0] load_follower;

  // ----------------------------------------------------------------
  // Write qualification
  // ----------------------------------------------------------------
  follower_check u_check (
    .wdata_i(cmd_i.data),
    .valid_o(count_ok)
  );

  // Writes while converting are dropped silently, as on a read-only word
  assign stack_wr = cmd_i.write && (cmd_i.code == CMD_PHASE_STACK)
                    && !conversion_en_i;
  // Override clear picks memory, set picks strap
  assign load_follower = stack_override_i ? strap_follower_i
                                          : nvm_follower_i;

  // ----------------------------------------------------------------
  // Stack word
  // ----------------------------------------------------------------
  // A write stores only a legal count; the rest keeps the old setting
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      follower_r <= PHASE_STACK_RESET[3:0];
    end else if (clk_en_i) begin
      if (load_i) begin
        follower_r <= load_follower;
      end else if (stack_wr && count_ok) begin
        follower_r <= cmd_i.data[FOLLOWER_MSB:FOLLOWER_LSB];
      end
    end
  end

  // Backchannel enable is decided only at power-up load, never by writes
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      bch_en_r <= 1'b0;
    end else if (clk_en_i && load_i) begin
      bch_en_r <= (load_follower != 4'h0);
    end
  end

  // Invalid-data flag pulses for the status logic outside
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      invalid_r <= 1'b0;
    end else if (clk_en_i) begin
      invalid_r <= stack_wr && !count_ok;
    end
  end

  // ----------------------------------------------------------------
  // Option word
  // ----------------------------------------------------------------
  // Reserved bits are not stored, so they read back as zero
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      option_r <= MISC_OPTION_RESET;
    end else if (clk_en_i) begin
      if (load_i) begin
        option_r <= nvm_option_i & OPT_WRITE_MASK;
      end else if (cmd_i.write && cmd_i.code == CMD_MISC_OPTION) begin
        option_r <= cmd_i.data & OPT_WRITE_MASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output voltage target with boot reload
  // ----------------------------------------------------------------
  // Reload wins over a same-cycle target write: shutdown is the stronger event
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      target_r <= 16'h0000;
    end else if (clk_en_i) begin
      if (control_shutdown_i && option_r[OPT_RELOAD_CTRL]) begin
        target_r <= boot_voltage_level_i;
      end else if (fault_restart_i && retry_mode_i
                   && option_r[OPT_RELOAD_RETRY]) begin
        target_r <= boot_voltage_level_i;
      end else if (target_write_en_i) begin
        target_r <= target_write_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Read data registered one cycle after the command
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_r <= 16'h0000;
      rvalid_r <= 1'b0;
    end else if (clk_en_i) begin
      rvalid_r <= cmd_i.read && (cmd_i.code == CMD_PHASE_STACK
                                 || cmd_i.code == CMD_MISC_OPTION);
      if (cmd_i.read && cmd_i.code == CMD_PHASE_STACK) begin
        rdata_r <= {STACK_UPPER_VALUE, STACK_ADDR_VALUE,
                    follower_r};
      end else if (cmd_i.read && cmd_i.code == CMD_MISC_OPTION) begin
        rdata_r <= option_r;
      end else begin
        rdata_r <= 16'h0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Decoded controls
  // ----------------------------------------------------------------
  always_comb begin
    option_o.pec_required = option_r[OPT_PEC_REQ];
    option_o.reload_on_control_off = option_r[OPT_RELOAD_CTRL];
    option_o.reload_on_retry = option_r[OPT_RELOAD_RETRY];
    option_o.pin_is_reset = option_r[OPT_PIN_RESET];
    // Pull-up only in reset mode, and then active when bit 3 is low
    option_o.pullup_en = option_r[OPT_PIN_RESET]
                         && !option_r[OPT_PULLUP_OFF];
    option_o.fault_counter_mode = option_r[OPT_FAULT_MODE];
    case (option_r[OPT_RES_MSB:OPT_RES_LSB])
      2'h0: option_o.telemetry_converter_width = RES_W_12;
      2'h1: option_o.telemetry_converter_width = RES_W_10;
      2'h2: option_o.telemetry_converter_width = RES_W_8;
      default: option_o.telemetry_converter_width = RES_W_6;
    endcase
  end

  assign rdata_o = rdata_r;
  assign rvalid_o = rvalid_r;
  assign invalid_data_o = invalid_r;
  assign follower_count_o = follower_r;
  assign backchannel_en_o = bch_en_r;
  assign output_voltage_target_o = target_r;
endmodule

/* File: common/stack_misc_pkg.sv */
// Shared constants and carriers for the stack and option word bank.
// Assumes a word-wide command port supplied by the bus front end.
package stack_misc_pkg;

  // ----------------------------------------------------------------
  // Command codes and field layout
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_PHASE_STACK = 8'hec;
  localparam logic [7:0] CMD_MISC_OPTION = 8'hed;

  localparam int FOLLOWER_LSB = 0;
  localparam int FOLLOWER_MSB = 3;
  localparam logic [3:0] FOLLOWER_MAX = 4'h3;
  localparam logic [3:0] STACK_ADDR_VALUE = 4'h0;
  localparam logic [7:0] STACK_UPPER_VALUE = 8'h00;

  localparam int OPT_PEC_REQ = 15;
  localparam int OPT_RELOAD_CTRL = 14;
  localparam int OPT_RELOAD_RETRY = 13;
  localparam int OPT_PIN_RESET = 12;
  localparam int OPT_PULLUP_OFF = 3;
  localparam int OPT_FAULT_MODE = 2;
  localparam int OPT_RES_MSB = 1;
  localparam int OPT_RES_LSB = 0;

  // Bits held in the option word; reserved bits 11:4 read zero
  localparam logic [15:0] OPT_WRITE_MASK = 16'hf00f;
  localparam logic [15:0] PHASE_STACK_RESET = 16'h0000;
  localparam logic [15:0] MISC_OPTION_RESET = 16'h0000;

  // Converter widths in bits per resolution code
  localparam logic [3:0] RES_W_12 = 4'hc;
  localparam logic [3:0] RES_W_10 = 4'ha;
  localparam logic [3:0] RES_W_8 = 4'h8;
  localparam logic [3:0] RES_W_6 = 4'h6;

  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] code;
    logic [15:0] data;
  } cmd_req_t;

  typedef struct packed {
    logic pec_required;
    logic reload_on_control_off;
    logic reload_on_retry;
    logic pin_is_reset;
    logic pullup_en;
    logic fault_counter_mode;
    logic [3:0] telemetry_converter_width;
  } option_ctl_t;

endpackage

/* File: hdl/follower_check.sv */
// Validates a follower count written to the stack word.
// Assumes a purely combinational use inside the register bank.
`timescale 1ns/10ps
module follower_check (
  input wire logic [15:0] wdata_i,
  output logic valid_o
);
  import stack_misc_pkg::*;

  // Only counts 0..3 are legal; upper bits are read-only and ignored
  always_comb begin
    valid_o = (wdata_i[FOLLOWER_MSB:FOLLOWER_LSB] <= FOLLOWER_MAX);
  end
endmodule

/* File: verification/host_cmd_model.sv */
// Host model that issues word commands to the bank.
// Assumes commands are sampled on the rising edge of sys_clk_i.
`timescale 1ns/10ps
module host_cmd_model (
  input wire logic sys_clk_i,
  output stack_misc_pkg::cmd_req_t cmd_o
);
  import stack_misc_pkg::*;
  initial cmd_o = '0;
  // One-cycle strobe; lines show the inverse once released
  task automatic xfer(input logic w, input logic [7:0] c,
                      input logic [15:0] d);
    @(posedge sys_clk_i);
    cmd_o <= '{w, !w, c,
               (c == CMD_MISC_OPTION) ? d & OPT_WRITE_MASK : d};
    @(posedge sys_clk_i);
    cmd_o <= '{1'b0, 1'b0, ~c, ~d};
  endtask
endmodule

/* File: verification/stack_misc_assertions.sv */
// Checker for the stack and option word bank.
// Assumes it is bound to the bank and sees its ports only.
`timescale 1ns/10ps
module stack_misc_assertions (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire stack_misc_pkg::cmd_req_t cmd_i,
  input wire logic conversion_en_i,
  input wire logic load_i,
  input wire logic control_shutdown_i,
  input wire logic [15:0] boot_voltage_level_i,
  input wire logic [15:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic invalid_data_o,
  input wire logic [3:0] follower_count_o,
  input wire logic backchannel_en_o,
  input wire stack_misc_pkg::option_ctl_t option_o,
  input wire logic [15:0] output_voltage_target_o
);
  import stack_misc_pkg::*;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // Rst inside go keeps $past from seeing pre-reset edges
  logic go;
  logic stk_wr;
  assign go = !rst_i && clk_en_i && !load_i;
  assign stk_wr = go && cmd_i.write && cmd_i.code == CMD_PHASE_STACK;
  a_stack_read: assert property (
    $past(go && cmd_i.read && cmd_i.code == CMD_PHASE_STACK) |->
    rvalid_o && rdata_o == {12'h000, follower_count_o})
    else $error("bad stack read");
  a_count_range: assert property (
    follower_count_o <= FOLLOWER_MAX) else $error("count above three");
  a_bad_count: assert property (
    $past(stk_wr && !conversion_en_i && cmd_i.data[3:0] > FOLLOWER_MAX)
    |-> invalid_data_o && $stable(follower_count_o))
    else $error("bad count not flagged");
  a_stack_locked: assert property (
    $past(!rst_i && !load_i && conversion_en_i) |->
    $stable(follower_count_o)) else $error("stack changed in conversion");
  a_backchan_hold: assert property (
    $past(!rst_i && !load_i) |-> $stable(backchannel_en_o))
    else $error("backchannel changed without load");
  a_opt_write: assert property (
    $past(go && cmd_i.write && cmd_i.code == CMD_MISC_OPTION) |->
    {option_o.pec_required, option_o.pin_is_reset,
     option_o.fault_counter_mode} ==
    $past({cmd_i.data[15], cmd_i.data[12], cmd_i.data[2]}))
    else $error("option write not applied");
  a_pullup_mode: assert property (
    option_o.pullup_en |-> option_o.pin_is_reset)
    else $error("pull-up on in power-good mode");
  a_ctrl_reload: assert property (
    $past(go && control_shutdown_i && option_o.reload_on_control_off) |->
    output_voltage_target_o == $past(boot_voltage_level_i))
    else $error("target not reloaded");
endmodule
bind stack_misc_regs stack_misc_assertions u_stack_misc_assertions (.*);

/* File: verification/stack_misc_regs_tb_top.sv */
// Self-checking bench for the stack and option word bank.
// Assumes the host model drives cmd_i; clock enable stays high.
`timescale 1ns/10ps
module stack_misc_regs_tb_top;
  import stack_misc_pkg::*;
  logic sys_clk_i = 1'b0, rst_i = 1'b1, clk_en_i = 1'b1;
  logic conversion_en_i = 1'b0, load_i = 1'b0, retry_mode_i = 1'b0;
  logic stack_override_i = 1'b0; // Override clear for memory load
  logic control_shutdown_i = 1'b0, fault_restart_i = 1'b0;
  logic target_write_en_i = 1'b0, rvalid_o, invalid_data_o, backchannel_en_o;
  logic [3:0] nvm_follower_i = 4'h0, strap_follower_i = 4'h3, follower_count_o;
  logic [15:0] nvm_option_i = 16'h0001, boot_voltage_level_i = 16'h1234;
  logic [15:0] target_write_i = 16'h0aaa, rdata_o, output_voltage_target_o;
  cmd_req_t cmd_i;
  option_ctl_t option_o;
  int n_errors = 0, cmp_count = 0;
  initial begin
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  stack_misc_regs u_stack_misc_regs (.*);
  host_cmd_model u_host_cmd_model (.sys_clk_i(sys_clk_i), .cmd_o(cmd_i));
  task automatic chk(input string nm, input logic [15:0] e, g);
    cmp_count++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask
  // Look at one-cycle answers mid-cycle, clear of the edge
  task automatic op(input logic w, input logic [7:0] c, input logic [15:0] d);
    u_host_cmd_model.xfer(w, c, d);
    @(negedge sys_clk_i);
  endtask
  // Pulses {load, target write, restart, shutdown} for one cycle
  task automatic ev(input logic [3:0] k);
    @(posedge sys_clk_i);
    {load_i, target_write_en_i, fault_restart_i, control_shutdown_i} <= k;
    @(posedge sys_clk_i);
    {load_i, target_write_en_i, fault_restart_i, control_shutdown_i} <= 4'h0;
    @(negedge sys_clk_i);
  endtask
  task automatic s_boot;
    ev(4'h8);
    chk("bc_off", 1'b0, backchannel_en_o);
    chk("nvm_cnt", 4'h0, follower_count_o);
    chk("nvm_opt", RES_W_10, option_o.telemetry_converter_width);
    op(1'b1, CMD_PHASE_STACK, 16'h0002);
    chk("bc_late", 1'b0, backchannel_en_o);
    chk("cnt2", 4'h2, follower_count_o);
    @(posedge sys_clk_i);
    stack_override_i <= 1'b1;
    ev(4'h8);
    chk("strap_cnt", 4'h3, follower_count_o);
    op(1'b1, CMD_PHASE_STACK, 16'h0000);
    chk("bc_live", 1'b1, backchannel_en_o);
    chk("cnt0", 4'h0, follower_count_o);
  endtask
  task automatic s_stack;
    op(1'b1, CMD_PHASE_STACK, 16'hfff1);
    op(1'b0, CMD_PHASE_STACK, 16'h0000);
    chk("stack_rd", 16'h0001, rdata_o);
    chk("stack_rvalid", 1'b1, rvalid_o);
    op(1'b1, CMD_PHASE_STACK, 16'h0007);
    chk("inval", 1'b1, invalid_data_o);
    chk("cnt_kept", 4'h1, follower_count_o);
    @(posedge sys_clk_i);
    conversion_en_i <= 1'b1;
    op(1'b1, CMD_PHASE_STACK, 16'h0002);
    chk("locked", 4'h1, follower_count_o);
  endtask
  task automatic s_options;
    logic [3:0] w [4];
    w = '{RES_W_12, RES_W_10, RES_W_8, RES_W_6};
    for (int r = 0; r < 4; r++) begin
      op(1'b1, CMD_MISC_OPTION, 16'hfffc | 16'(r));
      chk("width", w[r], option_o.telemetry_converter_width);
      op(1'b0, CMD_MISC_OPTION, 16'h0000);
      chk("opt_rd", 16'hf00c | 16'(r), rdata_o);
    end
    chk("pec", 1'b1, option_o.pec_required);
    chk("cnt_mode", 1'b1, option_o.fault_counter_mode);
    chk("pull_off", 1'b0, option_o.pullup_en);
    op(1'b1, CMD_MISC_OPTION, 16'h1000);
    chk("pull_on", 1'b1, option_o.pullup_en);
    op(1'b1, CMD_MISC_OPTION, 16'h0008);
    chk("power_good_output", 1'b0, option_o.pin_is_reset);
    chk("power_good_output_pull", 1'b0, option_o.pullup_en);
  endtask
  // Each reload bit must act only on its own event
  task automatic s_reload;
    @(posedge sys_clk_i);
    retry_mode_i <= 1'b1;
    op(1'b1, CMD_MISC_OPTION, 16'h4000);
    ev(4'h4);
    ev(4'h2);
    chk("no_retry", 16'h0aaa, output_voltage_target_o);
    ev(4'h1);
    chk("ctl_boot", 16'h1234, output_voltage_target_o);
    op(1'b1, CMD_MISC_OPTION, 16'h2000);
    ev(4'h4);
    ev(4'h1);
    chk("no_ctl", 16'h0aaa, output_voltage_target_o);
    ev(4'h2);
    chk("retry_boot", 16'h1234, output_voltage_target_o);
    // Restart with retry off must leave the target alone
    ev(4'h4);
    @(posedge sys_clk_i);
    retry_mode_i <= 1'b0;
    ev(4'h2);
    chk("no_mode", 16'h0aaa, output_voltage_target_o);
  endtask
  task automatic end_of_test;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    s_boot();
    s_stack();
    s_options();
    s_reload();
    end_of_test();
  end
endmodule
